// [src/clock_divider_control_defines.svh]
`ifndef DIVCTL_DEFINES_SVH
`define DIVCTL_DEFINES_SVH

// ============================================================
// Register bus geometry
`define CDC_ADDR_W          4
`define CDC_DATA_W          16

// ============================================================
// Register offsets
`define CDC_CTRL_OFS        4'h0
`define CDC_STAT_OFS        4'h4

// ============================================================
// Control register field positions
`define CDC_RECOVER_BIT     15
`define CDC_DOZE_LSB        12
`define CDC_SLOWEN_BIT      11
`define CDC_PSC_LSB         8

// ============================================================
// Status register field positions
`define CDS_ACTIVE_BIT      0
`define CDS_RATIO_LSB       1
`define CDS_OSC_LSB         4
`define CDS_PSC_ON_BIT      7
`define CDS_RECOV_BIT       8

// ============================================================
// Reset values
`define CDC_RECOVER_RST     1'h0
`define CDC_DOZE_RST        3'h3
`define CDC_SLOWEN_RST      1'h0
`define CDC_PSC_RST         3'h1

// ============================================================
// Oscillator selections that route through the postscaler
`define OSC_SEL_FAST_RC     3'h7
`define OSC_SEL_SLOW_RC     3'h6

`endif

// [src/clock_divider_control_pkg.sv]
package divctl_pkg;

    // ============================================================
    // Shared types
    typedef logic [2:0] ratio_t;        // Power-of-two exponent

    // Writable fields of the control register
    typedef struct packed {
        logic   recover;                // Recover on interrupt
        ratio_t doze_ratio;             // CPU slowdown exponent
        logic   slow_en;                // Slowdown enable
        ratio_t postscale;              // Postscaler exponent
    } ctrl_fields_t;

    // Whole state of the top module
    typedef struct packed {
        ctrl_fields_t ctrl;             // Control register
        logic         recovered;        // Sticky: doze cancelled by irq
        logic [15:0]  rdata;            // Read data register
    } top_state_t;

    // Whole state of one tick divider
    typedef struct packed {
        logic [7:0] count;              // Source ticks since last wrap
    } div_state_t;

endpackage

// [src/tick_div_if.sv]
`timescale 1ns/1ps

// ============================================================
// Carrier between control logic and one tick divider
interface tick_div_if;
    logic                  tick_in;    // Source clock enable
    divctl_pkg::ratio_t    ratio;      // Live divide exponent
    logic                  tick_out;   // Divided clock enable

    modport div_side  (input tick_in, input ratio, output tick_out);
    modport ctrl_side (output tick_in, output ratio, input tick_out);
endinterface

// [src/pow2_tick_div.sv]
`timescale 1ns/1ps

// ============================================================
// Divide a tick stream by 2^ratio
module pow2_tick_div (
    input  wire logic       clk,
    input  wire logic       reset,
    tick_div_if.div_side    link
);

    divctl_pkg::div_state_t s_q;        // Registered state
    divctl_pkg::div_state_t s_d;        // Next state
    logic [7:0]             mask;       // Last count of a period
    logic                   wrap;       // Period ends on this tick

    // Ratio read live; compare with >= so a shrink below the count ends the
    // running period on the next source tick, never mid-tick
    assign mask = 8'((9'h001 << link.ratio) - 9'h001);
    assign wrap = (s_q.count >= mask);

    // One-cycle enable, aligned with the source tick
    assign link.tick_out = link.tick_in && wrap;

    // ============================================================
    // Next-state logic
    always_comb begin
        s_d = s_q;
        if (link.tick_in) begin
            // Restart on wrap, else count source ticks
            if (wrap) begin
                s_d.count = 8'h00;
            end else begin
                s_d.count = s_q.count + 8'h01;
            end
        end
    end

    // ============================================================
    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule // pow2_tick_div

// [src/osc_tick_select.sv]
`timescale 1ns/1ps
`include "clock_divider_control_defines.svh"

// ============================================================
// Pick the source tick by oscillator selection
module osc_tick_select (
    input  wire logic [2:0] current_oscillator_select,
    input  wire logic       fast_rc_tick,
    input  wire logic       slow_rc_tick,
    input  wire logic       primary_tick,
    output logic            src_tick,
    output logic            postscale_on
);

    // ============================================================
    // Source mux; only the two RC sources see the postscaler
    always_comb begin
        if (current_oscillator_select == `OSC_SEL_FAST_RC) begin
            src_tick     = fast_rc_tick;
            postscale_on = 1'b1;
        end else if (current_oscillator_select == `OSC_SEL_SLOW_RC) begin
            src_tick     = slow_rc_tick;
            postscale_on = 1'b1;
        end else begin
            // Other oscillators bypass the postscaler
            src_tick     = primary_tick;
            postscale_on = 1'b0;
        end
    end

endmodule // osc_tick_select

// [src/clock_divider_doze_control.sv]
`timescale 1ns/1ps
`include "clock_divider_control_defines.svh"


// ============================================================
// Clock divider and CPU slowdown control
module clock_divider_doze_control (
    input  wire logic                      clk,
    input  wire logic                      reset,
    // Register port
    input  wire logic [`CDC_ADDR_W-1:0]    reg_addr,
    input  wire logic [`CDC_DATA_W-1:0]    reg_wdata,
    input  wire logic                      reg_wr,
    input  wire logic                      reg_rd,
    output logic      [`CDC_DATA_W-1:0]    reg_rdata,
    // Oscillator side
    input  wire logic [2:0]                current_oscillator_select,
    input  wire logic                      fast_rc_tick,
    input  wire logic                      slow_rc_tick,
    input  wire logic                      primary_tick,
    // Interrupt request from the controller
    input  wire logic                      irq_request,
    // Clock enables and slowdown status
    output logic                           periph_clk_en,
    output logic                           cpu_clk_en,
    output logic                           doze_active
);

    // ============================================================
    // State
    divctl_pkg::top_state_t  s_q;          // Registered state
    divctl_pkg::top_state_t  s_d;          // Next state

    // ============================================================
    // Internal nets
    logic                    src_tick;     // Selected source tick
    logic                    postscale_on; // Source uses postscaler
    divctl_pkg::ratio_t      cpu_ratio;    // Effective slowdown
    logic                    irq_recover;  // Interrupt cancels doze
    logic                    ctrl_hit;     // Address is control
    logic                    stat_hit;     // Address is status
    logic [`CDC_DATA_W-1:0]  ctrl_word;    // Control readback
    logic [`CDC_DATA_W-1:0]  stat_word;    // Status readback

    tick_div_if psc_link ();               // Postscaler carrier
    tick_div_if doze_link ();              // Slowdown carrier

    // ============================================================
    // Source selection
    osc_tick_select u_sel (
        .current_oscillator_select (current_oscillator_select),
        .fast_rc_tick              (fast_rc_tick),
        .slow_rc_tick              (slow_rc_tick),
        .primary_tick              (primary_tick),
        .src_tick                  (src_tick),
        .postscale_on              (postscale_on)
    );

    // ============================================================
    // Postscaler: divide the RC source by 2^fast_rc_postscale
    // Bypass sources see ratio zero, so ticks pass unchanged
    assign psc_link.tick_in = src_tick;
    assign psc_link.ratio   = postscale_on ? s_q.ctrl.postscale : 3'h0;

    pow2_tick_div u_psc (
        .clk   (clk),
        .reset (reset),
        .link  (psc_link)
    );

    // Peripheral clock is the postscaler output
    assign periph_clk_en = psc_link.tick_out;

    // ============================================================
    // Slowdown: CPU gets one of every 2^N peripheral ticks
    // Both enables come from the same source tick, so the CPU
    // edge always coincides with a peripheral edge
    assign cpu_ratio = s_q.ctrl.slow_en ? s_q.ctrl.doze_ratio : 3'h0;

    assign doze_link.tick_in = psc_link.tick_out;
    assign doze_link.ratio   = cpu_ratio;

    pow2_tick_div u_doze (
        .clk   (clk),
        .reset (reset),
        .link  (doze_link)
    );

    // CPU clock enable
    assign cpu_clk_en = doze_link.tick_out;

    // ============================================================
    // Address decode
    assign ctrl_hit = (reg_addr == `CDC_CTRL_OFS);
    assign stat_hit = (reg_addr == `CDC_STAT_OFS);

    // Recovery only when the option is set
    assign irq_recover = irq_request && s_q.ctrl.recover;

    // ============================================================
    // Readback words; bits 7..0 of control read zero
    always_comb begin
        ctrl_word                    = '0;
        ctrl_word[`CDC_RECOVER_BIT]  = s_q.ctrl.recover;
        ctrl_word[`CDC_DOZE_LSB+:3]  = s_q.ctrl.doze_ratio;
        ctrl_word[`CDC_SLOWEN_BIT]   = s_q.ctrl.slow_en;
        ctrl_word[`CDC_PSC_LSB+:3]   = s_q.ctrl.postscale;
    end

    // Status shows what the dividers really apply
    always_comb begin
        stat_word                    = '0;
        stat_word[`CDS_ACTIVE_BIT]   = (cpu_ratio != 3'h0);
        stat_word[`CDS_RATIO_LSB+:3] = cpu_ratio;
        stat_word[`CDS_OSC_LSB+:3]   = current_oscillator_select;
        stat_word[`CDS_PSC_ON_BIT]   = postscale_on;
        stat_word[`CDS_RECOV_BIT]    = s_q.recovered;
    end

    // ============================================================
    // Next-state logic
    always_comb begin
        s_d = s_q;

        // Software write to the control register
        if (reg_wr && ctrl_hit) begin
            s_d.ctrl.recover    = reg_wdata[`CDC_RECOVER_BIT];
            s_d.ctrl.doze_ratio = reg_wdata[`CDC_DOZE_LSB+:3];
            s_d.ctrl.slow_en    = reg_wdata[`CDC_SLOWEN_BIT];
            s_d.ctrl.postscale  = reg_wdata[`CDC_PSC_LSB+:3];
        end

        // Write one clears the sticky recovery flag
        if (reg_wr && stat_hit && reg_wdata[`CDS_RECOV_BIT]) begin
            s_d.recovered = 1'b0;
        end

        // Interrupt recovery beats a same-cycle software set;
        // the ratio field itself is kept for the next doze
        if (irq_recover) begin
            s_d.ctrl.slow_en = 1'b0;
            // Flag set wins over a same-cycle clear
            if (s_q.ctrl.slow_en) begin
                s_d.recovered = 1'b1;
            end
        end

        // Read data stand only in the cycle after the strobe
        if (reg_rd) begin
            if (ctrl_hit) begin
                s_d.rdata = ctrl_word;
            end else if (stat_hit) begin
                s_d.rdata = stat_word;
            end else begin
                // Unmapped address reads zero
                s_d.rdata = '0;
            end
        end else begin
            s_d.rdata = '0;
        end
    end

    // ============================================================
    // State register
    always_ff @(posedge clk) begin
        if (reset) begin
            s_q.ctrl.recover    <= `CDC_RECOVER_RST;
            s_q.ctrl.doze_ratio <= `CDC_DOZE_RST;
            s_q.ctrl.slow_en    <= `CDC_SLOWEN_RST;
            s_q.ctrl.postscale  <= `CDC_PSC_RST;
            s_q.recovered       <= 1'b0;
            s_q.rdata           <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ============================================================
    // Registered outputs
    assign reg_rdata   = s_q.rdata;
    assign doze_active = s_q.ctrl.slow_en;

endmodule // clock_divider_doze_control

// [verif/cdc_monitor.sv]
`timescale 1ns/1ps

// ======
// Port checker for the divider control
module cdc_monitor (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [2:0]  current_oscillator_select,
    input wire logic        fast_rc_tick,
    input wire logic        slow_rc_tick,
    input wire logic        primary_tick,
    input wire logic        irq_request,
    input wire logic        periph_clk_en,
    input wire logic        cpu_clk_en,
    input wire logic        doze_active
);
    typedef struct packed {
        logic               rec; // Shadow recover bit
        divctl_pkg::ratio_t rc;  // Shadow postscale
    } shadow_t;
    shadow_t    sh_q;   // Shadow of control writes
    shadow_t    sh_d;   // Next shadow
    logic       ctl_wr; // Control write this cycle
    logic [2:0] osc;    // Short alias
    assign ctl_wr = reg_wr && reg_addr == 4'h0;
    assign osc = current_oscillator_select;
    // Follow software; interrupts never touch these fields
    always_comb begin
        sh_d = sh_q;
        if (ctl_wr) begin
            sh_d = {reg_wdata[15], reg_wdata[10:8]};
        end
    end
    always_ff @(posedge clk) begin
        sh_q <= reset ? {1'b0, 3'h1} : sh_d;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ======
    // Assertions
    chk_cpu_in_periph: assert property (cpu_clk_en |-> periph_clk_en)
        else $error("cpu enable outside periph enable");
    chk_irq_clears: assert property (sh_q.rec && irq_request |=> !doze_active)
        else $error("interrupt left slowdown on");
    chk_irq_keeps: assert property (!sh_q.rec && irq_request && !ctl_wr |=> $stable(doze_active))
        else $error("interrupt changed slowdown");
    chk_write_enable: assert property (ctl_wr && !(sh_q.rec && irq_request) |=> doze_active == $past(reg_wdata[11]))
        else $error("slowdown enable not written");
    chk_ratio_off: assert property (!doze_active && periph_clk_en |-> cpu_clk_en)
        else $error("cpu slowed while disabled");
    chk_fast_pass: assert property (osc == 3'h7 && sh_q.rc == 3'h0 && fast_rc_tick |-> periph_clk_en)
        else $error("fast tick not passed");
    chk_slow_pass: assert property (osc == 3'h6 && sh_q.rc == 3'h0 && slow_rc_tick |-> periph_clk_en)
        else $error("slow tick not passed");
    chk_div2_spacing: assert property (sh_q.rc == 3'h1 && $past(sh_q.rc) == 3'h1 && osc == 3'h7 && $past(osc) == 3'h7
        && periph_clk_en |-> !$past(periph_clk_en))
        else $error("divide by two broken");
    cover property (sh_q.rec && irq_request && doze_active);
    cover property (doze_active && periph_clk_en && !cpu_clk_en);
    cover property (osc == 3'h6 && periph_clk_en);
endmodule // cdc_monitor

bind clock_divider_doze_control cdc_monitor i_mon (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .current_oscillator_select, .fast_rc_tick, .slow_rc_tick, .primary_tick, .irq_request,
    .periph_clk_en, .cpu_clk_en, .doze_active);

// [verif/tb_top.sv]
`timescale 1ns/1ps

// ======
// Bench for the divider control
module tb_top;
    typedef struct packed {
        logic [2:0]  osc;  // Oscillator selection
        logic [15:0] ctrl; // Control word
        logic [15:0] per;  // Periph pulses per window
        logic [15:0] cpu;  // CPU pulses per window
    } row_t;
    logic        clk;
    logic        reset;
    logic [3:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic [2:0]  osc;
    logic        slow = 1'b0; // Half-rate slow tick
    logic        irq;
    logic        periph_clk_en;
    logic        cpu_clk_en;
    logic        doze_active;
    row_t        rows[20];
    int          n_mismatch;
    int          comparisons;
    logic [15:0] got; // Read data seen
    logic [15:0] np;  // Periph pulses counted
    logic [15:0] nc;  // CPU pulses counted

    clock_divider_doze_control i_dut (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .current_oscillator_select(osc), .fast_rc_tick(1'b1), .slow_rc_tick(slow), .primary_tick(1'b1),
        .irq_request(irq), .periph_clk_en, .cpu_clk_en, .doze_active);

    // Free running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Slow source at half the fast rate
    always @(posedge clk) begin
        slow <= ~slow;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        got = reg_rdata;
    endtask
    // Count enables at the falling edge, where they are settled
    task automatic run(input int n);
        np = 16'h0;
        nc = 16'h0;
        repeat (n) begin
            @(negedge clk);
            if (periph_clk_en === 1'b1) np++;
            if (cpu_clk_en === 1'b1) nc++;
        end
    endtask
    task automatic pulse_irq;
        @(posedge clk);
        irq <= 1'b1;
        @(posedge clk);
        irq <= 1'b0;
    endtask
    task automatic close_out;
        $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 16'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        osc = 3'h7;
        irq = 1'b0;
        n_mismatch = 0;
        comparisons = 0;
        // Every postscale code, then every slowdown code
        for (int i = 0; i < 8; i++) begin
            rows[i] = '{3'h7, 16'(i << 8), 16'(256 >> i), 16'(256 >> i)};
            rows[8 + i] = '{3'h7, 16'(i << 12) | 16'h0800, 16'h100, 16'(256 >> i)};
        end
        rows[16] = '{3'h6, 16'h0000, 16'h80, 16'h80};
        rows[17] = '{3'h6, 16'h0300, 16'h10, 16'h10};
        rows[18] = '{3'h0, 16'h0700, 16'h100, 16'h100};
        rows[19] = '{3'h7, 16'h7000, 16'h100, 16'h100};
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        rd(4'h0);
        chk("ctrl reset", 16'h3100, got);
        run(16);
        chk("periph after reset", 16'h8, np);
        // Long settle first: a growing ratio stretches the old period
        foreach (rows[i]) begin
            osc <= rows[i].osc;
            wr(4'h0, rows[i].ctrl);
            run(512);
            run(256);
            chk("periph count", rows[i].per, np);
            chk("cpu count", rows[i].cpu, nc);
        end
        wr(4'h0, 16'ha800);
        pulse_irq;
        @(negedge clk);
        chk("doze after irq", 16'h0, {15'h0, doze_active});
        rd(4'h0);
        chk("ctrl after irq", 16'ha000, got);
        run(256);
        chk("cpu after irq", 16'h100, nc);
        rd(4'h4);
        chk("recovered flag", 16'h0100, got & 16'h0100);
        wr(4'h4, 16'h0100);
        rd(4'h4);
        chk("recovered clear", 16'h0, got & 16'h0100);
        wr(4'h0, 16'h2800);
        pulse_irq;
        rd(4'h0);
        chk("ctrl kept", 16'h2800, got);
        run(64);
        run(256);
        chk("cpu kept slow", 16'h40, nc);
        rd(4'h2);
        chk("unmapped read", 16'h0, got);
        wr(4'h0, 16'hffff);
        rd(4'h0);
        chk("low bits", 16'hff00, got);
        // One-edge reset in mid-run
        @(posedge clk);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        rd(4'h0);
        chk("ctrl rerun", 16'h3100, got);
        chk("doze rerun", 16'h0, {15'h0, doze_active});
        close_out;
    end
endmodule // tb_top
